// [src/txf_frame_tail.sv]
// Transmit-request frame parser: options, payload forwarding and checksum check.

// Notes on behaviour
// - Offset 15 byte is broadcast hop limit.
// - Zero hop limit uses configured maximum hops.
// - Offset 16 options; zero uses default options.
// - Bit0 disables ack, bit1 disables route discovery.
// - Bit2 enables NACK, bit3 enables trace route.
// - Bits 7:6 select delivery method.
// - Payload from offset 17, forwarded in order.
// - Checksum is 0xFF minus low sum byte.
// - Escaped mode sums original unescaped bytes.
// - Framing mode one plain, two escaped.
// - Length field MSB first, counts inner bytes.
// - Frame identifier echoed in status frame 0x8B.
// - Zero frame identifier requests no status.
module txf_frame_tail (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial byte stream from the host link
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Payload towards the radio
  output logic pay_valid,
  output logic [7:0] pay_data,
  output logic pay_last,
  input wire logic pay_ready,
  // Per-frame request description
  output logic req_valid,
  output logic [7:0] req_hops,
  output logic req_no_ack,
  output logic req_no_route,
  output logic req_nack,
  output logic req_trace,
  output logic [1:0] req_method,
  output logic req_status_wanted,
  output logic [7:0] req_status_type,
  output logic [7:0] req_frame_id
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  txf_pkg::txf_state_e state_q;
  logic [1:0] mode_q;
  logic enable_q;
  logic [7:0] max_hops_q;
  logic [7:0] def_opts_q;
  logic esc_q;
  logic [15:0] ofs_q;
  logic [15:0] len_q;
  logic [7:0] sum_q;
  logic [7:0] frame_id_q;
  logic [7:0] hops_q;
  logic [7:0] opts_q;
  logic [15:0] good_cnt_q;
  logic [15:0] bad_cnt_q;
  logic last_bad_q;
  logic [7:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_flush;
  logic f_valid;
  logic [7:0] f_data;
  logic f_ready;
  logic [7:0] held_q;
  logic held_v_q;
  logic commit_q;
  logic byte_take;
  logic raw_take;
  logic [7:0] cur;
  logic is_delim;
  logic is_esc;
  logic [15:0] end_ofs;
  logic apb_wr;
  logic apb_rd;
  logic [7:0] opts_eff;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [7:0] v, input logic [7:0] dflt);
    pick = (v == 8'h00) ? dflt : v;
  endfunction : pick

  assign opts_eff = pick(opts_q, def_opts_q);

  // ---------------------------------------------------------------
  // Byte intake and unescaping
  // ---------------------------------------------------------------
  // The payload holding stage stalls the link when the FIFO is full.
  assign rx_ready = (state_q != txf_pkg::TXF_PAYLOAD) || !held_v_q || fifo_in_ready;
  assign raw_take = rx_valid && rx_ready;
  assign is_delim = (rx_data == txf_pkg::DELIM);
  // An unescaped delimiter inside a frame in escaped mode restarts parsing only while enable_q is set.
  assign is_esc = (mode_q == txf_pkg::MODE_ESCAPED) && (rx_data == txf_pkg::ESC)
                  && !esc_q && (state_q != txf_pkg::TXF_IDLE);
  assign cur = esc_q ? (rx_data ^ txf_pkg::ESC_XOR) : rx_data;
  assign byte_take = raw_take && !is_esc && !(is_delim && !esc_q &&
                     (mode_q == txf_pkg::MODE_ESCAPED || state_q == txf_pkg::TXF_IDLE));
  assign end_ofs = len_q + 16'h0002;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      esc_q <= 1'b0;
    end else if (raw_take) begin
      esc_q <= is_esc;
    end
  end

  // ---------------------------------------------------------------
  // Frame state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= txf_pkg::TXF_IDLE;
      ofs_q <= '0;
      len_q <= '0;
      sum_q <= '0;
    end else if (raw_take && is_delim && !esc_q && enable_q &&
                 (state_q == txf_pkg::TXF_IDLE || mode_q == txf_pkg::MODE_ESCAPED)) begin
      state_q <= txf_pkg::TXF_HEAD;
      ofs_q <= txf_pkg::OFS_LEN_MSB;
      sum_q <= '0;
    end else if (byte_take) begin
      ofs_q <= ofs_q + 16'h0001;
      if (state_q != txf_pkg::TXF_CSUM && ofs_q >= txf_pkg::OFS_TYPE) begin
        sum_q <= sum_q + cur;
      end
      case (state_q)
        txf_pkg::TXF_HEAD: begin
          if (ofs_q == txf_pkg::OFS_LEN_MSB) begin
            len_q[15:8] <= cur;
          end else if (ofs_q == txf_pkg::OFS_LEN_LSB) begin
            len_q[7:0] <= cur;
          end else if (ofs_q == txf_pkg::OFS_TYPE) begin
            state_q <= (cur == txf_pkg::TYPE_TX_REQ) ? txf_pkg::TXF_FIELDS : txf_pkg::TXF_IDLE;
          end
        end
        txf_pkg::TXF_FIELDS: begin
          if (ofs_q == txf_pkg::OFS_OPTIONS) begin
            state_q <= (ofs_q == end_ofs) ? txf_pkg::TXF_CSUM : txf_pkg::TXF_PAYLOAD;
          end
        end
        txf_pkg::TXF_PAYLOAD: begin
          if (ofs_q == end_ofs) begin
            state_q <= txf_pkg::TXF_CSUM;
          end
        end
        txf_pkg::TXF_CSUM: begin
          state_q <= txf_pkg::TXF_IDLE;
        end
        default: begin
          state_q <= txf_pkg::TXF_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Header fields
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frame_id_q <= '0;
      hops_q <= '0;
      opts_q <= '0;
    end else if (byte_take && state_q == txf_pkg::TXF_FIELDS) begin
      if (ofs_q == txf_pkg::OFS_FRAME_ID) begin
        frame_id_q <= cur;
      end else if (ofs_q == txf_pkg::OFS_HOPS) begin
        hops_q <= cur;
      end else if (ofs_q == txf_pkg::OFS_OPTIONS) begin
        // Undefined option bits are not interpreted.
        opts_q <= cur;
      end
    end
  end

  // ---------------------------------------------------------------
  // Payload path: a held byte is pushed only once the next one shows
  // it is not the checksum; the FIFO output is released on a good sum.
  // ---------------------------------------------------------------
  assign fifo_in = held_q;
  // The last payload byte stays held past the checksum and is pushed once committed.
  assign fifo_in_valid = held_v_q && ((byte_take && state_q == txf_pkg::TXF_PAYLOAD) ||
                         (commit_q && state_q != txf_pkg::TXF_PAYLOAD &&
                          state_q != txf_pkg::TXF_CSUM));
  assign fifo_flush = byte_take && state_q == txf_pkg::TXF_CSUM &&
                      (sum_q + cur != txf_pkg::CSUM_BASE);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      held_q <= '0;
      held_v_q <= 1'b0;
    end else if (byte_take && state_q == txf_pkg::TXF_PAYLOAD) begin
      held_q <= cur;
      held_v_q <= 1'b1;
    end else if (fifo_in_valid && fifo_in_ready) begin
      held_v_q <= 1'b0;
    end else if (!commit_q &&
                 (state_q == txf_pkg::TXF_IDLE || state_q == txf_pkg::TXF_HEAD)) begin
      held_v_q <= 1'b0;
    end
  end

  txf_fifo #(.WIDTH(8), .DEPTH(txf_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Payload frames are at most FIFO depth plus one byte for lossless discard.
  assign f_ready = commit_q && (!pay_valid || pay_ready);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      commit_q <= 1'b0;
      pay_valid <= 1'b0;
      pay_data <= '0;
      pay_last <= 1'b0;
    end else begin
      if (byte_take && state_q == txf_pkg::TXF_CSUM && (sum_q + cur == txf_pkg::CSUM_BASE)) begin
        commit_q <= 1'b1;
      end else if (commit_q && !f_valid && !held_v_q) begin
        commit_q <= 1'b0;
      end
      if (f_valid && f_ready) begin
        pay_valid <= 1'b1;
        pay_data <= f_data;
        pay_last <= 1'b0;
      end else if (pay_ready) begin
        pay_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Request description, issued once per accepted frame
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_valid <= 1'b0;
      req_hops <= '0;
      req_no_ack <= 1'b0;
      req_no_route <= 1'b0;
      req_nack <= 1'b0;
      req_trace <= 1'b0;
      req_method <= '0;
      req_status_wanted <= 1'b0;
      req_status_type <= '0;
      req_frame_id <= '0;
    end else begin
      req_valid <= byte_take && state_q == txf_pkg::TXF_CSUM &&
                   (sum_q + cur == txf_pkg::CSUM_BASE);
      if (byte_take && state_q == txf_pkg::TXF_CSUM &&
          (sum_q + cur == txf_pkg::CSUM_BASE)) begin
        req_hops <= pick(hops_q, max_hops_q);
        req_no_ack <= opts_eff[txf_pkg::OPT_NO_ACK];
        req_no_route <= opts_eff[txf_pkg::OPT_NO_ROUTE];
        req_nack <= opts_eff[txf_pkg::OPT_NACK];
        req_trace <= opts_eff[txf_pkg::OPT_TRACE];
        req_method <= opts_eff[txf_pkg::OPT_METHOD_LO +: 2];
        req_status_wanted <= (frame_id_q != 8'h00);
        req_status_type <= txf_pkg::TYPE_TX_STATUS;
        req_frame_id <= frame_id_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Statistics
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      good_cnt_q <= '0;
      bad_cnt_q <= '0;
      last_bad_q <= 1'b0;
    end else if (byte_take && state_q == txf_pkg::TXF_CSUM) begin
      if (sum_q + cur == txf_pkg::CSUM_BASE) begin
        good_cnt_q <= good_cnt_q + 16'h0001;
        last_bad_q <= 1'b0;
      end else begin
        bad_cnt_q <= bad_cnt_q + 16'h0001;
        last_bad_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB register file, zero wait states
  // ---------------------------------------------------------------
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_q <= txf_pkg::RST_MODE;
      enable_q <= 1'b1;
      max_hops_q <= txf_pkg::RST_MAX_HOPS;
      def_opts_q <= txf_pkg::RST_DEF_OPTS;
    end else if (apb_wr) begin
      if (paddr == txf_pkg::ADDR_CTRL) begin
        mode_q <= pwdata[1:0];
        enable_q <= pwdata[4];
      end else if (paddr == txf_pkg::ADDR_CFG) begin
        max_hops_q <= pwdata[7:0];
        def_opts_q <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == txf_pkg::ADDR_CTRL ||
                 paddr == txf_pkg::ADDR_CFG || ((paddr == txf_pkg::ADDR_STATUS ||
                 paddr == txf_pkg::ADDR_LAST || paddr == txf_pkg::ADDR_COUNT) && !pwrite));
      if (apb_rd) begin
        if (paddr == txf_pkg::ADDR_CTRL) begin
          prdata <= {27'h0000000, enable_q, 2'h0, mode_q};
        end else if (paddr == txf_pkg::ADDR_CFG) begin
          prdata <= {16'h0000, def_opts_q, max_hops_q};
        end else if (paddr == txf_pkg::ADDR_STATUS) begin
          prdata <= {23'h000000, last_bad_q, 5'h00, 3'(state_q)};
        end else if (paddr == txf_pkg::ADDR_LAST) begin
          prdata <= {8'h00, frame_id_q, opts_q, hops_q};
        end else if (paddr == txf_pkg::ADDR_COUNT) begin
          prdata <= {bad_cnt_q, good_cnt_q};
        end else begin
          prdata <= '0;
        end
      end
    end
  end

endmodule : txf_frame_tail

// [src/txf_pkg.sv]
// Package of constants and types for the transmit-request frame parser.
package txf_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam logic [7:0] DELIM = 8'h7E;
  localparam logic [7:0] ESC = 8'h7D;
  localparam logic [7:0] XON = 8'h11;
  localparam logic [7:0] XOFF = 8'h13;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
  localparam logic [7:0] TYPE_TX_REQ = 8'h10;
  localparam logic [7:0] TYPE_TX_STATUS = 8'h8B;
  localparam logic [15:0] OFS_LEN_MSB = 16'h0001;
  localparam logic [15:0] OFS_LEN_LSB = 16'h0002;
  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_FRAME_ID = 16'h0004;
  localparam logic [15:0] OFS_HOPS = 16'h000F;
  localparam logic [15:0] OFS_OPTIONS = 16'h0010;
  localparam logic [15:0] OFS_PAYLOAD = 16'h0011;

  // ---------------------------------------------------------------
  // Transmit-options fields
  // ---------------------------------------------------------------
  localparam int OPT_NO_ACK = 0;
  localparam int OPT_NO_ROUTE = 1;
  localparam int OPT_NACK = 2;
  localparam int OPT_TRACE = 3;
  localparam int OPT_METHOD_LO = 6;
  localparam logic [1:0] METHOD_P2MP = 2'h1;
  localparam logic [1:0] METHOD_REPEATER = 2'h2;
  localparam logic [1:0] METHOD_MESH = 2'h3;

  // ---------------------------------------------------------------
  // Framing modes and register map
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_PLAIN = 2'h1;
  localparam logic [1:0] MODE_ESCAPED = 2'h2;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LAST = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [1:0] RST_MODE = 2'h1;
  localparam logic [7:0] RST_MAX_HOPS = 8'h00;
  localparam logic [7:0] RST_DEF_OPTS = 8'h00;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    TXF_IDLE, TXF_HEAD, TXF_FIELDS, TXF_PAYLOAD, TXF_CSUM
  } txf_state_e;

endpackage : txf_pkg

// [src/txf_fifo.sv]
// Parameterised flip-flop FIFO with valid and ready on both sides.
module txf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule : txf_fifo

// [bench/txf_frame_tail_asserts.sv]
// Port-level checks for the transmit-request frame parser.
module txf_frame_tail_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Payload and request
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  input wire logic pay_ready,
  input wire logic req_valid,
  input wire logic req_status_wanted,
  input wire logic [7:0] req_status_type,
  input wire logic [7:0] req_frame_id
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_pready_setup: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing in access phase");
  a_pready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_status_type: assert property (req_valid |-> req_status_type == 8'h8B)
    else $error("wrong status frame type");
  a_status_wanted: assert property (req_valid |->
    req_status_wanted == (req_frame_id != 8'h00))
    else $error("status request does not follow frame id");
  a_req_pulse: assert property ($rose(req_valid) |=> !req_valid [*2])
    else $error("req_valid wider than one cycle");
  a_pay_hold: assert property (pay_valid && !pay_ready |=>
    pay_valid && $stable(pay_data))
    else $error("payload dropped while stalled");
  a_id_stands: assert property (!req_valid |-> $stable(req_frame_id))
    else $error("frame id changed without a request");
endmodule : txf_frame_tail_asserts

bind txf_frame_tail txf_frame_tail_asserts txf_frame_tail_asserts_inst (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
  .req_valid(req_valid), .req_status_wanted(req_status_wanted),
  .req_status_type(req_status_type), .req_frame_id(req_frame_id));

// [bench/txf_host_model.sv]
// Host model that sends transmit-request frames over the byte link.
module txf_host_model (
  // Clock
  input wire logic clock,
  // Byte link
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int stalls = 0;
  initial begin
    rx_valid = 1'h0;
    rx_data = 8'hA5;
  end
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    rx_valid <= 1'h1;
    rx_data <= b;
    do begin
      @(posedge clock);
      n++;
    end while (rx_ready !== 1'h1 && n < 100);
    if (n >= 100) stalls++;
  endtask : put
  task automatic put_enc(input logic esc, input logic [7:0] b);
    if (esc && (b == txf_pkg::DELIM || b == txf_pkg::ESC || b == txf_pkg::XON
        || b == txf_pkg::XOFF)) begin
      put(txf_pkg::ESC);
      put(b ^ txf_pkg::ESC_XOR);
    end else begin
      put(b);
    end
  endtask : put_enc
  task automatic send_frame(input logic esc, input logic [7:0] id, input logic [7:0] hops,
      input logic [7:0] opts, input logic [7:0] pl[$], input logic bad);
    logic [7:0] body[$];
    logic [7:0] sum;
    logic [15:0] len;
    body = {txf_pkg::TYPE_TX_REQ, id, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13,
      8'hFF, 8'hFE, hops, opts};
    body = {body, pl};
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    len = 16'(body.size());
    @(posedge clock);
    put(txf_pkg::DELIM);
    put_enc(esc, len[15:8]);
    put_enc(esc, len[7:0]);
    foreach (body[i]) put_enc(esc, body[i]);
    put_enc(esc, (txf_pkg::CSUM_BASE - sum) ^ {7'h00, bad});
    rx_valid <= 1'h0;
    rx_data <= ~rx_data;
  endtask : send_frame
endmodule : txf_host_model

// [bench/tb_txf_frame_tail.sv]
// Self-checking bench for the transmit-request frame parser.
module tb_txf_frame_tail;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pay_ready = 1'h1;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_ready, pay_valid, pay_last, req_valid;
  logic req_no_ack, req_no_route, req_nack, req_trace, req_status_wanted;
  logic [7:0] rx_data, pay_data, req_hops, req_status_type, req_frame_id;
  logic [1:0] req_method;
  logic [7:0] got[$];
  logic [7:0] max_h = 8'h00;
  logic [7:0] def_o = 8'h00;
  int fails = 0;
  int tests_run = 0;
  int reqs = 0;
  always #4 clock = ~clock;
  txf_frame_tail txf_frame_tail_inst (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .pay_valid(pay_valid), .pay_data(pay_data), .pay_last(pay_last),
    .pay_ready(pay_ready), .req_valid(req_valid), .req_hops(req_hops),
    .req_no_ack(req_no_ack), .req_no_route(req_no_route), .req_nack(req_nack),
    .req_trace(req_trace), .req_method(req_method), .req_status_wanted(req_status_wanted),
    .req_status_type(req_status_type), .req_frame_id(req_frame_id));
  txf_host_model txf_host_model_inst (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready));
  always @(posedge clock) begin
    if (pay_valid === 1'h1 && pay_ready === 1'h1) got.push_back(pay_data);
    if (req_valid === 1'h1) reqs++;
  end
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic hung();
    fails++;
    give_verdict();
  endtask : hung
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic exp_err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) hung();
    if (!wr && !exp_err) check("prdata", prdata, exp);
    check("pslverr", 32'(pslverr), 32'(exp_err));
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic frame(input logic esc, input logic [7:0] id, input logic [7:0] hops,
      input logic [7:0] opts, input logic [7:0] pl[$], input logic bad);
    logic [7:0] o;
    int r0, n;
    o = (opts == 8'h00) ? def_o : opts;
    got.delete();
    r0 = reqs;
    txf_host_model_inst.send_frame(esc, id, hops, opts, pl, bad);
    n = 0;
    while (got.size() < (bad ? 0 : pl.size()) && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) hung();
    repeat (20) @(posedge clock);
    check("requests", reqs - r0, bad ? 0 : 1);
    check("payload count", 32'(got.size()), bad ? 0 : 32'(pl.size()));
    check("pay_last", 32'(pay_last), 32'h0);
    if (!bad) begin
      check("hops", 32'(req_hops), 32'(hops == 8'h00 ? max_h : hops));
      check("no_ack", 32'(req_no_ack), 32'(o[0]));
      check("no_route", 32'(req_no_route), 32'(o[1]));
      check("nack", 32'(req_nack), 32'(o[2]));
      check("trace", 32'(req_trace), 32'(o[3]));
      check("method", 32'(req_method), 32'(o[7:6]));
      check("frame id", 32'(req_frame_id), 32'(id));
      check("status", 32'(req_status_wanted), 32'(id != 8'h00));
      foreach (pl[i]) check("payload", 32'(got[i]), 32'(pl[i]));
    end
  endtask : frame
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'h1;
    apb(1'h0, txf_pkg::ADDR_CTRL, 32'h0, 32'h11, 1'h0);
    apb(1'h0, txf_pkg::ADDR_CFG, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h40, 32'h0, 32'h0, 1'h1);
    apb(1'h1, txf_pkg::ADDR_STATUS, 32'h1, 32'h0, 1'h1);
    apb(1'h1, txf_pkg::ADDR_CFG, 32'hC105, 32'h0, 1'h0);
    max_h = 8'h05;
    def_o = 8'hC1;
    apb(1'h0, txf_pkg::ADDR_CFG, 32'h0, 32'hC105, 1'h0);
    frame(1'h0, 8'h01, 8'h00, 8'h00, '{8'h54, 8'h7E, 8'h7D}, 1'h0);
    frame(1'h0, 8'h00, 8'h07, 8'h41, '{8'hA5}, 1'h0);
    frame(1'h0, 8'h22, 8'hFF, 8'h82, '{8'h01, 8'h02}, 1'h0);
    frame(1'h0, 8'h33, 8'h03, 8'hCC, '{8'h10, 8'h20}, 1'h1);
    apb(1'h0, txf_pkg::ADDR_STATUS, 32'h0, 32'h100, 1'h0);
    frame(1'h0, 8'h44, 8'h02, 8'hCC, '{8'h11}, 1'h0);
    apb(1'h1, txf_pkg::ADDR_CTRL, 32'h12, 32'h0, 1'h0);
    apb(1'h0, txf_pkg::ADDR_CTRL, 32'h0, 32'h12, 1'h0);
    frame(1'h1, 8'h7D, 8'h13, 8'h43, '{8'h7E, 8'h7D, 8'h11, 8'h13, 8'h20}, 1'h0);
    apb(1'h1, txf_pkg::ADDR_CTRL, 32'h02, 32'h0, 1'h0);
    frame(1'h1, 8'h66, 8'h01, 8'h01, '{8'h7E}, 1'h1);
    apb(1'h1, txf_pkg::ADDR_CTRL, 32'h12, 32'h0, 1'h0);
    pay_ready <= 1'h0;
    fork
      frame(1'h1, 8'h05, 8'h01, 8'h81, '{8'h7E, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h11}, 1'h0);
      begin
        repeat (120) @(posedge clock);
        check("stalled payload", 32'(got.size()), 32'h0);
        check("payload held", 32'(pay_valid), 32'h1);
        pay_ready <= 1'h1;
      end
    join
    check("host stalls", txf_host_model_inst.stalls, 32'h0);
    apb(1'h0, txf_pkg::ADDR_COUNT, 32'h0, 32'h00010006, 1'h0);
    apb(1'h0, txf_pkg::ADDR_LAST, 32'h0, 32'h00058101, 1'h0);
    give_verdict();
  end
endmodule : tb_txf_frame_tail
